// ### verilog/trajectory_segment_buffer_consts.vh
`ifndef TRAJECTORY_SEGMENT_BUFFER_CONSTS_VH
`define TRAJECTORY_SEGMENT_BUFFER_CONSTS_VH
`define IDX_SEGMENT_COMMAND 16'h2010
`define IDX_BUFFER_FREE_COUNT 16'h2011
`define IDX_BUFFER_STATUS_WORD 16'h2012
`define IDX_EXPECTED_SEGMENT_NUMBER 16'h2013
`define BUF_DEPTH 32
`define CMD_CLEAR 7'h00
`define CMD_POP 7'h01
`define CMD_CLEAR_ERR 7'h02
`define CMD_RESET_ID 7'h03
`define CMD_NOP 7'h04
`define FMT_PVT_ABS 4'h0
`define FMT_PVT_ABS_X100 4'h1
`define FMT_PVT_REL 4'h2
`define FMT_PVT_REL_X100 4'h3
`define FMT_LOAD_POS 4'h4
`define FMT_LIN_ABS 4'h5
`define FMT_LIN_REL 4'h6
`define ERR_SEQ_BIT 0
`define ERR_OVF_BIT 1
`define ERR_UNF_BIT 2
`define FIFO_DEPTH 4
`endif

// ### verilog/seg_fifo.v
`timescale 1ns/100ps
`default_nettype none
module seg_fifo #(
  parameter WIDTH = 64,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rp_q];
  always @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
    if (rst) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // seg_fifo
`default_nettype wire

// ### verilog/trajectory_segment_buffer.v
// What this block does
// - header bit 7 set means buffer command
// - code 0 clears buffer, aborts profile
// - code 1 pops N newest segments
// - code 2 clears masked error bits
// - code 3 resets expected segment id
// - code 4 does nothing
// - bit 7 clear: counter and format fields
// - format 0: time, 24-bit position, velocity
// - format 1: velocity in 10 counts/s
// - formats 2,3: relative position variants
// - format 4 loads 32-bit reference position
// - format 5: linear segment, absolute position
// - format 6 relative linear; 7-15 reserved
// - segment ids start 0, increment by one
// - bad counter flags error, blocks segments
// - status bits 0-15 expected id
// - status bits 16-23 free count
// - bits 24-26 sequence, overflow, underflow errors
// - bit 31 set when buffer empty
// - event on error set or removal
// - buffer holds thirty-two segments
// - control bit 4 rising starts move, unless code 0 or 1 runs that cycle
// - underflow while running aborts profile, unless code 1 runs that cycle
`timescale 1ns/100ps
`default_nettype none
`include "trajectory_segment_buffer_consts.vh"
module trajectory_segment_buffer #(
  parameter DEPTH = `BUF_DEPTH,
  parameter AW = 5
) (
  input wire clk,
  input wire rst,
  input wire wr_valid,
  output wire wr_ready,
  input wire [15:0] wr_index,
  input wire [63:0] wr_data,
  input wire [15:0] rd_index,
  output reg [31:0] rd_data,
  input wire ctrl_start,
  input wire seg_take,
  output reg seg_valid,
  output reg [1:0] seg_kind,
  output reg seg_rel,
  output reg [7:0] seg_time,
  output reg [31:0] seg_pos,
  output reg [31:0] seg_vel,
  output reg [1:0] seg_vel_scale,
  output reg running,
  output reg status_event,
  output reg [31:0] status_word
);
  localparam [1:0] KIND_PVT = 2'h0;
  localparam [1:0] KIND_LIN = 2'h1;
  localparam [1:0] SCALE_TENTH = 2'h0;
  localparam [1:0] SCALE_TEN = 2'h1;
  // entry: kind(2) rel(1) scale(2) time(8) pos(32) vel(32)
  localparam EW = 77;
  reg [EW-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] rd_q;
  reg [AW-1:0] wr_q;
  reg [AW:0] cnt_q;
  reg [15:0] id_q;
  reg seq_err_q;
  reg ovf_q;
  reg unf_q;
  reg run_q;
  reg start_s1_q;
  reg start_s2_q;
  reg start_prev_q;
  reg [31:0] ref_pos_q;
  reg ref_loaded_q;
  reg [2:0] err_prev_q;
  wire f_valid;
  wire [63:0] f_data;
  wire [15:0] f_index;
  seg_fifo #(.WIDTH(80), .DEPTH(`FIFO_DEPTH), .AW(2)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(wr_valid && wr_index == `IDX_SEGMENT_COMMAND),
    .in_ready(wr_ready),
    .in_data({wr_index, wr_data}),
    .out_valid(f_valid),
    .out_ready(1'b1),
    .out_data({f_index, f_data})
  );
  // first byte sits in the top lane of the 64-bit word
  wire [7:0] hdr = f_data[63:56];
  wire [7:0] b1 = f_data[55:48];
  wire [23:0] b2_4 = f_data[47:24];
  wire [23:0] b5_7 = f_data[23:0];
  wire [31:0] b1_4 = f_data[55:24];
  wire [31:0] b2_5 = f_data[47:16];
  wire is_cmd = f_valid && hdr[7];
  wire [6:0] cmd = hdr[6:0];
  wire is_seg = f_valid && !hdr[7];
  wire [2:0] integ = hdr[2:0];
  wire [3:0] fmt = hdr[6:3];
  wire full = (cnt_q == DEPTH[AW:0]);
  wire empty = (cnt_q == {(AW+1){1'b0}});
  wire fmt_entry = (fmt <= `FMT_PVT_REL_X100) || fmt == `FMT_LIN_ABS || fmt == `FMT_LIN_REL;
  wire seq_ok = (integ == id_q[2:0]) && !seq_err_q;
  wire seg_in = is_seg && fmt_entry && seq_ok && !full;
  wire seg_ovf = is_seg && fmt_entry && seq_ok && full;
  wire pos_load = is_seg && fmt == `FMT_LOAD_POS && seq_ok;
  wire removal = run_q && seg_take && !empty;
  wire start_rise = start_s2_q && !start_prev_q;
  wire underflow = run_q && seg_take && empty;
  wire do_clear = is_cmd && cmd == `CMD_CLEAR;
  wire do_pop = is_cmd && cmd == `CMD_POP;
  wire do_clr_err = is_cmd && cmd == `CMD_CLEAR_ERR;
  wire do_rst_id = is_cmd && cmd == `CMD_RESET_ID;
  wire [AW:0] pop_n = ({1'b0, b1} >= {1'b0, cnt_q}) ? cnt_q : b1[AW:0];
  // a relative segment right after a loaded reference is stored as absolute, so the generator keeps no extra state
  wire [31:0] pvt_off = {{8{b2_4[23]}}, b2_4};
  wire [31:0] pvt_pos = (fmt[1] && ref_loaded_q) ? ref_pos_q + pvt_off : pvt_off;
  wire [31:0] lin_pos = (!fmt[0] && ref_loaded_q) ? ref_pos_q + b2_5 : b2_5;
  reg [EW-1:0] new_entry;
  always @* begin
    new_entry = {EW{1'b0}};
    case (fmt)
      `FMT_PVT_ABS, `FMT_PVT_ABS_X100, `FMT_PVT_REL, `FMT_PVT_REL_X100: begin
        new_entry = {KIND_PVT, fmt[1] && !ref_loaded_q, (fmt[0] ? SCALE_TEN : SCALE_TENTH), b1,
          pvt_pos, {{8{b5_7[23]}}, b5_7}};
      end
      `FMT_LIN_ABS, `FMT_LIN_REL: begin
        new_entry = {KIND_LIN, (fmt[0] == 1'b0) && !ref_loaded_q, SCALE_TENTH, b1, lin_pos, 32'h00000000};
      end
      default: begin
        new_entry = {EW{1'b0}};
      end
    endcase
  end
  wire [EW-1:0] head = mem[rd_q];
  wire [7:0] free_cnt = DEPTH[7:0] - {{(7-AW){1'b0}}, cnt_q};
  wire [2:0] err_now = {unf_q, ovf_q, seq_err_q};
  always @(posedge clk) begin
    if (seg_in) begin
      mem[wr_q] <= new_entry;
    end
    if (rst) begin
      rd_q <= {AW{1'b0}};
      wr_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      id_q <= 16'h0000;
      seq_err_q <= 1'b0;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      run_q <= 1'b0;
      start_s1_q <= 1'b0;
      start_s2_q <= 1'b0;
      start_prev_q <= 1'b0;
      ref_pos_q <= 32'h00000000;
      ref_loaded_q <= 1'b0;
      err_prev_q <= 3'h0;
    end else begin
      start_s1_q <= ctrl_start;
      start_s2_q <= start_s1_q;
      start_prev_q <= start_s2_q;
      err_prev_q <= err_now;
      if (do_clear) begin
        rd_q <= {AW{1'b0}};
        wr_q <= {AW{1'b0}};
        cnt_q <= {(AW+1){1'b0}};
        run_q <= 1'b0;
      end else if (do_pop) begin
        wr_q <= wr_q - pop_n[AW-1:0];
        cnt_q <= cnt_q - pop_n;
      end else begin
        if (seg_in) begin
          wr_q <= wr_q + 1'b1;
        end
        if (removal) begin
          rd_q <= rd_q + 1'b1;
        end
        if (seg_in && !removal) begin
          cnt_q <= cnt_q + 1'b1;
        end else if (removal && !seg_in) begin
          cnt_q <= cnt_q - 1'b1;
        end
        if (underflow) begin
          run_q <= 1'b0;
        end else if (start_rise) begin
          run_q <= 1'b1;
        end
      end
      // code 4 and unknown codes fall through with no effect
      if (do_rst_id) begin
        id_q <= 16'h0000;
      end else if (seg_in || pos_load) begin
        id_q <= id_q + 16'h0001;
      end
      if (pos_load) begin
        ref_pos_q <= b1_4;
        ref_loaded_q <= 1'b1;
      end else if (seg_in) begin
        ref_loaded_q <= 1'b0;
      end
      // set wins over the clear mask
      if (is_seg && fmt_entry && !seq_ok && !seq_err_q) begin
        seq_err_q <= 1'b1;
      end else if (is_seg && !seq_err_q && integ != id_q[2:0]) begin
        seq_err_q <= 1'b1;
      end else if (do_clr_err && b1[`ERR_SEQ_BIT]) begin
        seq_err_q <= 1'b0;
      end
      if (seg_ovf) begin
        ovf_q <= 1'b1;
      end else if (do_clr_err && b1[`ERR_OVF_BIT]) begin
        ovf_q <= 1'b0;
      end
      if (underflow) begin
        unf_q <= 1'b1;
      end else if (do_clr_err && b1[`ERR_UNF_BIT]) begin
        unf_q <= 1'b0;
      end
    end
  end
  // outputs registered; segment head is presented while running
  always @(posedge clk) begin
    if (rst) begin
      seg_valid <= 1'b0;
      seg_kind <= 2'h0;
      seg_rel <= 1'b0;
      seg_time <= 8'h00;
      seg_pos <= 32'h00000000;
      seg_vel <= 32'h00000000;
      seg_vel_scale <= 2'h0;
      running <= 1'b0;
      status_event <= 1'b0;
      status_word <= 32'h80000000;
      rd_data <= 32'h00000000;
    end else begin
      seg_valid <= run_q && !empty;
      {seg_kind, seg_rel, seg_vel_scale, seg_time, seg_pos, seg_vel} <= head;
      running <= run_q;
      status_event <= removal || |(err_now & ~err_prev_q);
      status_word <= {empty, 4'h0, err_now, free_cnt, id_q};
      if (rd_index == `IDX_BUFFER_FREE_COUNT) begin
        rd_data <= {24'h000000, free_cnt};
      end else if (rd_index == `IDX_BUFFER_STATUS_WORD) begin
        rd_data <= {empty, 4'h0, err_now, free_cnt, id_q};
      end else if (rd_index == `IDX_EXPECTED_SEGMENT_NUMBER) begin
        rd_data <= {16'h0000, id_q};
      end else begin
        rd_data <= 32'h00000000;
      end
    end
  end
endmodule // trajectory_segment_buffer
`default_nettype wire

// ### verif/fieldbus_master.sv
`timescale 1ns/100ps
`default_nettype none
module fieldbus_master (
  input wire logic clk,
  input wire logic wr_ready,
  output logic wr_valid,
  output logic [15:0] wr_index,
  output logic [63:0] wr_data
);
  initial begin
    wr_valid = 1'b0;
    wr_index = 16'h0;
    wr_data = 64'h0;
  end
  // request is held until the edge that sees ready, so back to back words need no idle cycle
  task automatic send(input logic [15:0] a, input logic [63:0] d);
    logic r;
    wr_valid <= 1'b1;
    wr_index <= a;
    wr_data <= d;
    do begin
      @(negedge clk);
      r = wr_ready;
      @(posedge clk);
    end while (!r);
  endtask
  // released data is inverted so a stale word never looks like a fresh one
  task automatic idle;
    wr_valid <= 1'b0;
    wr_data <= ~wr_data;
  endtask
  function automatic logic [63:0] seg(input logic [3:0] f, input logic [15:0] id, input logic [55:0] p);
    return {1'b0, f, id[2:0], p};
  endfunction
endmodule // fieldbus_master
`default_nettype wire

// ### verif/trajectory_segment_buffer_sva.sv
`timescale 1ns/100ps
`default_nettype none
module trajectory_segment_buffer_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic seg_take,
  input wire logic seg_valid,
  input wire logic running,
  input wire logic status_event,
  input wire logic [15:0] rd_index,
  input wire logic [31:0] rd_data,
  input wire logic [31:0] status_word
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_take; seg_take && seg_valid; endsequence
  sequence s_err_rise; (status_word[26:24] & ~$past(status_word[26:24])) != 3'h0; endsequence
  chk_free_bound: assert property (status_word[23:16] <= 8'h20)
    else $error("free count too big");
  chk_empty_flag: assert property (status_word[23:16] != 8'h0 |-> status_word[31] == (status_word[23:16] == 8'h20))
    else $error("empty flag wrong");
  chk_reserved_zero: assert property (status_word[30:27] == 4'h0)
    else $error("reserved bits set");
  chk_free_read: assert property (rd_index == 16'h2011 |=> rd_data == {24'h0, status_word[23:16]})
    else $error("free read wrong");
  chk_next_id_read: assert property (rd_index == 16'h2013 |=> rd_data == {16'h0, status_word[15:0]})
    else $error("id read wrong");
  chk_err_event: assert property (s_err_rise |-> status_event || $past(status_event))
    else $error("no event on error");
  chk_take_event: assert property (s_take |-> ##[1:3] status_event)
    else $error("no event on removal");
  chk_id_step: assert property ($changed(status_word[15:0]) |->
    status_word[15:0] == $past(status_word[15:0]) + 16'h1 || status_word[15:0] == 16'h0)
    else $error("id jumped");
  chk_seq_hold: assert property (status_word[24] && $past(status_word[24]) |->
    $stable(status_word[15:0]) || status_word[15:0] == 16'h0)
    else $error("segment taken during error");
  chk_unf_abort: assert property ($rose(status_word[26]) |-> ##[0:2] !running)
    else $error("profile kept running");
endmodule // trajectory_segment_buffer_sva
bind trajectory_segment_buffer trajectory_segment_buffer_sva u_trajectory_segment_buffer_sva (.*);
`default_nettype wire

// ### verif/tb_trajectory_segment_buffer.sv
`timescale 1ns/100ps
`default_nettype none
module tb_trajectory_segment_buffer;
  logic clk, rst, wr_valid, wr_ready, ctrl_start, seg_take, seg_valid, seg_rel, running, status_event;
  logic [15:0] wr_index, rd_index;
  logic [63:0] wr_data;
  logic [31:0] rd_data, seg_pos, seg_vel, status_word, m;
  logic [7:0] seg_time;
  logic [1:0] seg_kind, seg_vel_scale;
  logic [2:0] err = 3'h0;
  logic [3:0] fmts [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6};
  int miscompares = 0, check_count = 0, cyc = 0, cnt = 0, id = 0, i, t = 0;
  trajectory_segment_buffer u_trajectory_segment_buffer (.*);
  fieldbus_master u_fieldbus_master (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check_all;
    logic [31:0] e [4];
    u_fieldbus_master.idle();
    repeat (6) @(negedge clk);
    m = {cnt == 0, 4'h0, err, 8'(32 - cnt), id[15:0]};
    e = '{32'h0, {24'h0, m[23:16]}, m, {16'h0, m[15:0]}};
    chk(status_word, m);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      rd_index <= 16'h2010 + 16'(k);
      @(posedge clk);
      @(negedge clk);
      chk(rd_data, e[k]);
    end
    @(posedge clk);
    t++;
    $display("test %0d done", t);
  endtask
  task automatic push(input logic [3:0] f, input int s, input logic [55:0] p);
    u_fieldbus_master.send(16'h2010, u_fieldbus_master.seg(f, 16'(s), p));
    if (!err[0]) begin
      if (s[2:0] != id[2:0]) err[0] = 1'b1;
      else if (cnt == 32 && f != 4'h4) err[1] = 1'b1;
      else begin
        if (f != 4'h4) cnt++;
        id = (id + 1) % 65536;
      end
    end
  endtask
  task automatic cmd(input logic [6:0] c, input logic [7:0] a);
    u_fieldbus_master.send(16'h2010, {1'b1, c, a, 48'h0});
  endtask
  task automatic take;
    seg_take <= 1'b1;
    @(posedge clk);
    seg_take <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      summarize;
    end
  end
  initial begin
    rst = 1'b1;
    ctrl_start = 1'b0;
    seg_take = 1'b0;
    rd_index = 16'h0;
    void'($urandom(32'h30e6));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    check_all;
    for (i = 0; i < 33; i++) push(fmts[i % 6], i, {8'($urandom) | 8'h01, 48'({$urandom, $urandom})});
    check_all;
    cmd(7'h02, 8'h02);
    err[1] = 1'b0;
    cmd(7'h01, 8'h03);
    cnt -= 3;
    u_fieldbus_master.send(16'h2012, 64'hffffffffffffffff);
    check_all;
    push(4'h0, id + 1, 56'h01);
    push(4'h0, id, 56'h01);
    check_all;
    cmd(7'h02, 8'h01);
    err[0] = 1'b0;
    cmd(7'h04, 8'hff);
    check_all;
    cmd(7'h00, 8'h00);
    cmd(7'h03, 8'h00);
    cnt = 0;
    id = 0;
    check_all;
    push(4'h0, 0, {8'h05, 24'h800001, 24'h000123});
    push(4'h5, 1, {8'h09, 32'h12345678, 16'h0});
    ctrl_start <= 1'b1;
    check_all;
    @(negedge clk);
    chk(32'({running, seg_valid, seg_kind, seg_rel, seg_vel_scale, seg_time}), 32'h6005);
    chk(seg_pos, 32'hff800001);
    chk(seg_vel, 32'h00000123);
    @(posedge clk);
    take;
    cnt = 1;
    @(negedge clk);
    chk(32'({seg_kind, seg_rel, seg_time}), 32'h209);
    chk(seg_pos, 32'h12345678);
    @(posedge clk);
    take;
    take;
    cnt = 0;
    err[2] = 1'b1;
    check_all;
    @(negedge clk);
    chk({31'h0, running}, 32'h0);
    cmd(7'h02, 8'h04);
    err[2] = 1'b0;
    ctrl_start <= 1'b0;
    push(4'h4, 2, {32'h00001000, 24'h0});
    push(4'h2, 3, {8'h07, 24'h000010, 24'h0});
    ctrl_start <= 1'b1;
    check_all;
    @(negedge clk);
    chk(32'({running, seg_rel, seg_time}), 32'h207);
    chk(seg_pos, 32'h00001010);
    summarize;
  end
endmodule // tb_trajectory_segment_buffer
`default_nettype wire
